/* File: rtl/sia_device.sv */
// device end of the serial interrupt link: start, data frames, stop decode
`timescale 1ns/1ps
`include "sia_cfg.svh"
// What this block does
// - start low pulse totals four to eight clocks
// - quiet start: one low clock, then release
// - never start while a cycle is active
// - host extends start low, then drives high
// - quiet mode: line change triggers a start
// - continuous mode: only the host starts
// - host may run continuously or leave idle
// - mode changes in stop; reset is continuous
// - stop two clocks quiet, three continuous
// - measure every stop width, set next mode
// - tolerate idle clocks and late start
// - count three-clock frames from start rise
// - sample clock: drive low only if low
// - recovery: drive high only after own low
// - turn-around clock: always release the wire
// - send states whoever began the cycle
// - frame N sampled 3N-1 clocks after rise
// - frame three: management interrupt or IRQ2
// - frame fourteen carries IRQ13
// - after quiet stop, start from second clock
// - drive and sample on link clock rise
// - release wire in reset; start continuous
module sia_device (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  sia_link_if.device       link,
  input  wire logic [15:1] irqLevel,
  input  wire logic        system_mgmt_interrupt_n,
  input  wire logic        mgmt_interrupt_enable_mask,
  output logic             quietMode,
  output logic             cycleActive
);
  // ****************************************
  // pin synchronisation
  // ****************************************
  logic [17:0] syncIn;
  logic [17:0] syncOut;
  logic        linkClkS;
  logic        linkClkD;
  logic        linkRise;
  logic        sirqS;
  logic [15:1] irqS;
  logic        smiS;

  assign syncIn = {link.linkClk, link.sirq, system_mgmt_interrupt_n, irqLevel};

  sia_sync #(
    .WIDTH (18),
    .INIT  ({2'h3, 16'hffff})
  ) u_sync (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .d       (syncIn),
    .q       (syncOut)
  );

  assign linkClkS = syncOut[17];
  assign sirqS    = syncOut[16];
  assign smiS     = syncOut[15];
  assign irqS     = syncOut[14:0];

  // all link activity steps on the rising edge of the link clock
  assign linkRise = linkClkS & ~linkClkD;

  // ****************************************
  // frame contents
  // ****************************************
  logic [15:0] slotVec;
  logic [15:0] lastSent;
  logic        pending;

  // bit k rides in frame k+1; frame 1 is unused and always reads high
  always_comb begin
    slotVec     = {irqS, 1'b1};
    // shared slot: the mask picks management interrupt or IRQ2
    slotVec[`SIA_SHARED_SLOT] = mgmt_interrupt_enable_mask ? smiS
                                                           : irqS[`SIA_SHARED_SLOT];
  end

  // a level differing from what was last sent still needs a cycle
  assign pending = |(slotVec ^ lastSent);

  // ****************************************
  // link state machine
  // ****************************************
  sia_pkg::sia_dev_state_type state;
  sia_pkg::sia_dev_state_type next_state;
  logic [4:0]  frame;
  logic [4:0]  next_frame;
  logic [1:0]  phase;
  logic [1:0]  next_phase;
  logic [2:0]  width;
  logic [2:0]  next_width;
  logic        quiet;
  logic        next_quiet;
  logic        droveLow;
  logic        next_droveLow;
  logic        drvOe;
  logic        next_drvOe;
  logic        drvOut;
  logic        next_drvOut;
  logic [15:0] next_lastSent;
  logic [3:0]  slotIdx;

  // next state; the pins only change at a link edge, so each clock holds one drive value
  always_comb begin
    next_state    = state;
    next_frame    = frame;
    next_phase    = phase;
    next_width    = width;
    next_quiet    = quiet;
    next_droveLow = droveLow;
    next_lastSent = lastSent;
    next_drvOe    = drvOe;
    next_drvOut   = drvOut;
    slotIdx       = frame[3:0];
    if (linkRise) begin
      // default is released: covers turn-around and all idle clocks
      next_drvOe  = 1'b0;
      next_drvOut = 1'b1;
      unique case (state)
        sia_pkg::SIA_D_IDLE: begin
          if (!sirqS) begin
            next_state = sia_pkg::SIA_D_START;
          end else if (quiet && pending) begin
            // one low clock only, never driven high afterwards
            next_drvOe  = 1'b1;
            next_drvOut = 1'b0;
            next_state  = sia_pkg::SIA_D_OWN;
          end
        end
        sia_pkg::SIA_D_OWN: begin
          next_state = sia_pkg::SIA_D_START;
        end
        sia_pkg::SIA_D_START: begin
          // sirqS shows the clock just begun, so this is clock 0, the host's high clock;
          // it counts as a recovery slot so that frame 1 samples at clock 2, not clock 1
          if (sirqS) begin
            next_state = sia_pkg::SIA_D_FRAMES;
            next_frame = 5'h0;
            next_phase = `SIA_PH_RECOVER;
          end
        end
        sia_pkg::SIA_D_FRAMES: begin
          unique case (phase)
            `SIA_PH_TURN: begin
              if (frame == `SIA_LAST_DEV_FRAME) begin
                next_state = sia_pkg::SIA_D_STOPW;
              end else begin
                // sample clock of frame+1 lands at 3N-1 after the rise
                next_frame    = frame + 5'h1;
                next_phase    = `SIA_PH_SAMPLE;
                next_drvOe    = ~slotVec[slotIdx];
                next_drvOut   = 1'b0;
                next_droveLow = ~slotVec[slotIdx];
                next_lastSent[slotIdx] = slotVec[slotIdx];
              end
            end
            `SIA_PH_SAMPLE: begin
              next_phase  = `SIA_PH_RECOVER;
              next_drvOe  = droveLow;
              next_drvOut = 1'b1;
            end
            `SIA_PH_RECOVER: begin
              next_phase    = `SIA_PH_TURN;
              next_droveLow = 1'b0;
            end
            default: begin
              next_phase = `SIA_PH_TURN;
            end
          endcase
        end
        sia_pkg::SIA_D_STOPW: begin
          // any run of idle clocks before the stop pulse is fine
          if (!sirqS) begin
            next_width = 3'h1;
            next_state = sia_pkg::SIA_D_STOPL;
          end
        end
        sia_pkg::SIA_D_STOPL: begin
          if (!sirqS) begin
            if (width != `SIA_STOP_MAX) begin
              next_width = width + 3'h1;
            end
          end else if (width == `SIA_STOP_QUIET) begin
            next_quiet = 1'b1;
            next_state = sia_pkg::SIA_D_GAP;
          end else if (width == `SIA_STOP_CONT) begin
            next_quiet = 1'b0;
            next_state = sia_pkg::SIA_D_GAP;
          end else begin
            // another agent's slot pulse, not a stop; keep watching
            next_state = sia_pkg::SIA_D_STOPW;
          end
        end
        sia_pkg::SIA_D_GAP: begin
          // the clock right after the stop rise is not yet open for starts
          next_state = sia_pkg::SIA_D_IDLE;
        end
      endcase
    end
  end

  // registers; wire released and continuous mode out of reset
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state    <= sia_pkg::SIA_D_IDLE;
      frame    <= 5'h0;
      phase    <= `SIA_PH_TURN;
      width    <= 3'h0;
      quiet    <= 1'b0;
      droveLow <= 1'b0;
      lastSent <= 16'hffff;
      drvOe    <= 1'b0;
      drvOut   <= 1'b1;
      linkClkD <= 1'b1;
    end else begin
      state    <= next_state;
      frame    <= next_frame;
      phase    <= next_phase;
      width    <= next_width;
      quiet    <= next_quiet;
      droveLow <= next_droveLow;
      lastSent <= next_lastSent;
      drvOe    <= next_drvOe;
      drvOut   <= next_drvOut;
      linkClkD <= linkClkS;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign link.devOe  = drvOe;
  assign link.devOut = drvOut;
  assign quietMode   = quiet;
  assign cycleActive = (state == sia_pkg::SIA_D_FRAMES);
endmodule

/* File: rtl/sia_cfg.svh */
// timing counts and field codes of the serial interrupt agent
`ifndef SIA_CFG_SVH
`define SIA_CFG_SVH
`define SIA_REF_PERIOD_NS  100
`define SIA_LINK_HALF_NS   400
`define SIA_LINK_HALF_CLKS (`SIA_LINK_HALF_NS / `SIA_REF_PERIOD_NS)
`define SIA_PH_SAMPLE      2'h0
`define SIA_PH_RECOVER     2'h1
`define SIA_PH_TURN        2'h2
`define SIA_LAST_DEV_FRAME 5'h10
`define SIA_LAST_HOST_FRAME 5'h11
`define SIA_SHARED_SLOT    4'h2
`define SIA_STOP_QUIET     3'h2
`define SIA_STOP_CONT      3'h3
`define SIA_STOP_MAX       3'h7
`define SIA_EXT_MIN        3'h3
`define SIA_EXT_DEFAULT    3'h3
`endif

/* File: rtl/sia_pkg.sv */
// state types shared by both ends of the serial interrupt link
package sia_pkg;
  typedef enum logic [2:0] {
    SIA_D_IDLE, SIA_D_OWN, SIA_D_START, SIA_D_FRAMES, SIA_D_STOPW, SIA_D_STOPL, SIA_D_GAP
  } sia_dev_state_type;
  typedef enum logic [2:0] {
    SIA_H_IDLE, SIA_H_LOW, SIA_H_FRAMES, SIA_H_STOP, SIA_H_HIGH
  } sia_host_state_type;
endpackage

/* File: rtl/sia_link_if.sv */
// serial interrupt wire and its clock between the two ends
`timescale 1ns/1ps
interface sia_link_if;
  logic linkClk;
  logic devOut;
  logic devOe;
  logic hostOut;
  logic hostOe;
  logic sirq;
  // pulled-up shared wire: any enabled low driver wins
  assign sirq = (devOe ? devOut : 1'b1) & (hostOe ? hostOut : 1'b1);
  modport device (input linkClk, input sirq, output devOut, output devOe);
  modport host (output linkClk, input sirq, output hostOut, output hostOe);
endinterface

/* File: rtl/sia_sync.sv */
// two-stage synchroniser for a bundle of asynchronous levels
`timescale 1ns/1ps
module sia_sync #(
  parameter int         WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;
  // ****************************************
  // sync chain
  // ****************************************
  // stage one feeds only stage two; idle value on reset avoids a false start
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      meta <= INIT;
      q    <= INIT;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

/* File: rtl/sia_host.sv */
// host end of the serial interrupt link: clock, start, frame capture, stop
`timescale 1ns/1ps
`include "sia_cfg.svh"
module sia_host #(
  parameter int HALF_CLKS = `SIA_LINK_HALF_CLKS
) (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  sia_link_if.host         link,
  input  wire logic        startRequest,
  input  wire logic        selectQuiet,
  input  wire logic [2:0]  extendClks,
  output logic      [15:0] frameLevel,
  output logic             quietMode,
  output logic             cycleDone
);
  // ****************************************
  // link clock divider
  // ****************************************
  logic [7:0] halfCnt;
  logic [7:0] next_halfCnt;
  logic       linkClk;
  logic       toggle;
  logic       linkRise;
  logic       sirqS;
  logic [2:0] extend;

  assign toggle   = (halfCnt == 8'(HALF_CLKS - 1));
  assign linkRise = toggle & ~linkClk;
  assign next_halfCnt = toggle ? 8'h0 : halfCnt + 8'h1;
  // a request below the legal extension is raised to the least one
  assign extend = (extendClks < `SIA_EXT_MIN) ? `SIA_EXT_MIN : extendClks;

  sia_sync #(
    .WIDTH (1),
    .INIT  (1'b1)
  ) u_sync (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .d       (link.sirq),
    .q       (sirqS)
  );

  // ****************************************
  // link state machine
  // ****************************************
  sia_pkg::sia_host_state_type state;
  sia_pkg::sia_host_state_type next_state;
  logic [4:0]  frame;
  logic [4:0]  next_frame;
  logic [1:0]  phase;
  logic [1:0]  next_phase;
  logic [2:0]  cnt;
  logic [2:0]  next_cnt;
  logic        quiet;
  logic        next_quiet;
  logic        drvOe;
  logic        next_drvOe;
  logic        drvOut;
  logic        next_drvOut;
  logic [15:0] next_frameLevel;
  logic        next_done;

  // at each link rise: the sampled wire is the clock just ended, the drive is for the next
  always_comb begin
    next_state      = state;
    next_frame      = frame;
    next_phase      = phase;
    next_cnt        = cnt;
    next_quiet      = quiet;
    next_drvOe      = drvOe;
    next_drvOut     = drvOut;
    next_frameLevel = frameLevel;
    next_done       = 1'b0;
    if (linkRise) begin
      next_drvOe  = 1'b0;
      next_drvOut = 1'b1;
      unique case (state)
        sia_pkg::SIA_H_IDLE: begin
          if (quiet && !sirqS) begin
            // a device began; take over from the next clock
            next_drvOe  = 1'b1;
            next_drvOut = 1'b0;
            next_cnt    = extend - 3'h1;
            next_state  = sia_pkg::SIA_H_LOW;
          end else if (startRequest) begin
            // holding the request gives back-to-back cycles
            next_drvOe  = 1'b1;
            next_drvOut = 1'b0;
            next_cnt    = extend;
            next_state  = sia_pkg::SIA_H_LOW;
          end
        end
        sia_pkg::SIA_H_LOW: begin
          next_drvOe = 1'b1;
          if (cnt != 3'h0) begin
            next_drvOut = 1'b0;
            next_cnt    = cnt - 3'h1;
          end else begin
            next_drvOut = 1'b1;
            next_frame  = 5'h0;
            next_phase  = `SIA_PH_RECOVER;
            next_state  = sia_pkg::SIA_H_FRAMES;
          end
        end
        sia_pkg::SIA_H_FRAMES: begin
          unique case (phase)
            `SIA_PH_TURN: begin
              if (frame == `SIA_LAST_HOST_FRAME) begin
                // mode for the next cycle is fixed by the stop width
                next_drvOe  = 1'b1;
                next_drvOut = 1'b0;
                next_cnt    = selectQuiet ? `SIA_STOP_QUIET - 3'h1 : `SIA_STOP_CONT - 3'h1;
                next_quiet  = selectQuiet;
                next_state  = sia_pkg::SIA_H_STOP;
              end else begin
                next_frame = frame + 5'h1;
                next_phase = `SIA_PH_SAMPLE;
              end
            end
            `SIA_PH_SAMPLE: begin
              next_phase = `SIA_PH_RECOVER;
              if (frame <= `SIA_LAST_DEV_FRAME) begin
                next_frameLevel[4'(frame - 5'h1)] = sirqS;
              end
            end
            `SIA_PH_RECOVER: begin
              next_phase = `SIA_PH_TURN;
            end
            default: begin
              next_phase = `SIA_PH_TURN;
            end
          endcase
        end
        sia_pkg::SIA_H_STOP: begin
          next_drvOe = 1'b1;
          if (cnt != 3'h0) begin
            next_drvOut = 1'b0;
            next_cnt    = cnt - 3'h1;
          end else begin
            next_state = sia_pkg::SIA_H_HIGH;
          end
        end
        sia_pkg::SIA_H_HIGH: begin
          next_done  = 1'b1;
          next_state = sia_pkg::SIA_H_IDLE;
        end
      endcase
    end
  end

  // registers; reset releases the wire and leaves the link continuous
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      halfCnt    <= 8'h0;
      linkClk    <= 1'b0;
      state      <= sia_pkg::SIA_H_IDLE;
      frame      <= 5'h0;
      phase      <= `SIA_PH_TURN;
      cnt        <= 3'h0;
      quiet      <= 1'b0;
      drvOe      <= 1'b0;
      drvOut     <= 1'b1;
      frameLevel <= 16'hffff;
      cycleDone  <= 1'b0;
    end else begin
      halfCnt    <= next_halfCnt;
      linkClk    <= toggle ? ~linkClk : linkClk;
      state      <= next_state;
      frame      <= next_frame;
      phase      <= next_phase;
      cnt        <= next_cnt;
      quiet      <= next_quiet;
      drvOe      <= next_drvOe;
      drvOut     <= next_drvOut;
      frameLevel <= next_frameLevel;
      cycleDone  <= next_done;
    end
  end

  assign link.linkClk = linkClk;
  assign link.hostOe  = drvOe;
  assign link.hostOut = drvOut;
  assign quietMode    = quiet;
endmodule

/* File: verification/sia_link_chk.sv */
// concurrent checks on the serial interrupt wire shared by both ends
`timescale 1ns/1ps
// ************
// wire checker
// ************
module sia_link_chk (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic linkClk,
  input wire logic devOut,
  input wire logic devOe,
  input wire logic hostOut,
  input wire logic hostOe,
  input wire logic sirq
);
  logic [6:0] lowRun;
  logic [9:0] sinceStart;
  logic [3:0] sinceRise;
  logic [4:0] sinceStop;
  logic       linkPrev;
  logic       active;
  logic       quietSeen;
  logic       devLow;
  logic       devHigh;
  logic       stopEnd;
  logic       startEnd;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  assign devLow = devOe && !devOut;
  assign devHigh = devOe && devOut;
  // widths are measured in ref clocks, so a stop of 2 or 3 link clocks is 16 or 24
  assign stopEnd = sirq && (lowRun inside {[7'h0f:7'h11], [7'h17:7'h19]});
  assign startEnd = sirq && (lowRun >= 7'h1c);
  // wire phase trackers: low run, link clock age, cycle state and last stop mode
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      lowRun <= 7'h0;
      sinceStart <= 10'h3ff;
      sinceRise <= 4'h0;
      sinceStop <= 5'h0;
      linkPrev <= 1'b0;
      active <= 1'b0;
      quietSeen <= 1'b0;
    end else begin
      linkPrev <= linkClk;
      sinceRise <= (linkClk && !linkPrev) ? 4'h1 : sinceRise + 4'h1;
      lowRun <= sirq ? 7'h0 : lowRun + {6'h0, ~&lowRun};
      sinceStart <= startEnd ? 10'h1 : sinceStart + {9'h0, ~&sinceStart};
      sinceStop <= stopEnd ? 5'h1 : sinceStop + {4'h0, ~&sinceStop};
      if (startEnd) begin
        active <= 1'b1;
      end
      if (stopEnd) begin
        active <= 1'b0;
        quietSeen <= (lowRun <= 7'h11);
      end
    end
  end
  AST_RESET_RELEASE: assert property (
      disable iff (1'b0) !reset_n |=> !devOe && !hostOe)
    else $error("wire driven during reset");
  AST_PULSE_WIDTH: assert property (
      $rose(sirq) |-> lowRun == 7'h08 || stopEnd || startEnd)
    else $error("low pulse of illegal width");
  AST_DEV_LOW_ONE: assert property ($rose(devLow) |=> devLow [*7] ##1 !devLow)
    else $error("device low drive not one link clock");
  AST_DEV_HIGH_AFTER: assert property ($rose(devHigh) |-> $past(devLow))
    else $error("device drove high without own low");
  AST_DEV_HIGH_ONE: assert property ($rose(devHigh) |=> devHigh [*7] ##1 !devOe)
    else $error("device did not release after recovery");
  AST_HOST_HIGH_ONE: assert property (
      $rose(hostOe && hostOut) |=> hostOut [*7] ##1 !(hostOe && hostOut))
    else $error("host high drive not one link clock");
  AST_QUIET_ONLY: assert property ($rose(devLow) && !active |-> quietSeen)
    else $error("device started in continuous mode");
  AST_STOP_GAP: assert property ($rose(devLow) && !active |-> sinceStop >= 5'h09)
    else $error("device started too soon after stop");
  AST_SLOT_PHASE: assert property (
      $rose(devLow) && active |->
      (sinceStart % 10'h18) inside {[10'h11:10'h15]} && sinceStart < 10'h190)
    else $error("device drove outside a sample slot");
  AST_LINK_SYNC: assert property (
      $changed({devOe, devOut}) |-> sinceRise inside {[4'h2:4'h6]})
    else $error("device drive not tied to link clock rise");
  COV_DEV_START: cover property ($rose(devLow) && !active);
  COV_QUIET_STOP: cover property (stopEnd && lowRun <= 7'h11);
  COV_CONT_STOP: cover property (stopEnd && lowRun >= 7'h17);
  COV_HOST_HIGH: cover property ($rose(hostOe && hostOut));
endmodule

/* File: verification/test_serial_irq_agent.sv */
// self-checking bench for the device and host ends of the serial interrupt link
`timescale 1ns/1ps
// **********
// bench top
// **********
module test_serial_irq_agent;
  logic        refClk;
  logic        resetN;
  logic [15:1] irqLevel;
  logic        mgmtN;
  logic        mgmtSel;
  logic        startRequest;
  logic        selectQuiet;
  logic [2:0]  extendClks;
  logic [15:0] frameLevel;
  logic [15:0] seen;
  logic        hostQuiet;
  logic        devQuiet;
  logic        cycleActive;
  logic        cycleDone;
  logic        got;
  int          num_errors;
  int          n_checks;
  int          i;
  logic [15:1] pat [6] = '{15'h0000, 15'h5555, 15'h2aaa, 15'h5fff, 15'h7ffe, 15'h7fff};
  sia_link_if sia_link_if_inst ();
  sia_device sia_device_inst (.ref_clk(refClk), .reset_n(resetN), .link(sia_link_if_inst),
    .irqLevel(irqLevel), .system_mgmt_interrupt_n(mgmtN),
    .mgmt_interrupt_enable_mask(mgmtSel), .quietMode(devQuiet), .cycleActive(cycleActive));
  sia_host sia_host_inst (.ref_clk(refClk), .reset_n(resetN), .link(sia_link_if_inst),
    .startRequest(startRequest), .selectQuiet(selectQuiet), .extendClks(extendClks),
    .frameLevel(frameLevel), .quietMode(hostQuiet), .cycleDone(cycleDone));
  sia_link_chk sia_link_chk_inst (.ref_clk(refClk), .reset_n(resetN),
    .linkClk(sia_link_if_inst.linkClk), .devOut(sia_link_if_inst.devOut),
    .devOe(sia_link_if_inst.devOe), .hostOut(sia_link_if_inst.hostOut),
    .hostOe(sia_link_if_inst.hostOe), .sirq(sia_link_if_inst.sirq));
  // 10 MHz reference clock
  initial begin
    refClk = 1'b0;
    forever #50 refClk = ~refClk;
  end
  task automatic final_report;
    if (num_errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seenVal, input logic [15:0] want);
    n_checks++;
    if (seenVal !== want) begin
      num_errors++;
      $display("BAD t=%0t seen=%h want=%h", $time, seenVal, want);
    end
  endtask
  // write side: new interrupt levels land just after a falling edge
  task automatic put(input logic [15:1] lv, input logic sel, input logic smiN);
    @(negedge refClk);
    irqLevel = lv;
    mgmtSel = sel;
    mgmtN = smiN;
  endtask
  // bounded wait for the end-of-cycle pulse; absence is reported by the caller
  task automatic wait_done(input int limit, output logic done);
    done = 1'b0;
    for (int k = 0; k < limit && !done; k++) begin
      @(negedge refClk);
      done = (cycleDone === 1'b1);
    end
  endtask
  // read side: frame levels captured by the host at the end of one cycle
  task automatic read_frames(output logic [15:0] lv);
    logic done;
    wait_done(3000, done);
    if (!done) begin
      num_errors++;
      final_report();
    end
    lv = frameLevel;
  endtask
  task automatic wait_active;
    for (int k = 0; k < 3000 && cycleActive !== 1'b1; k++) begin
      @(negedge refClk);
    end
    if (cycleActive !== 1'b1) begin
      num_errors++;
      final_report();
    end
  endtask
  // frame 1 carries nothing, frame 3 carries the management line when selected
  function automatic logic [15:0] expect_frames(input logic [15:1] lv, input logic sel,
                                                input logic smiN);
    logic [15:0] e;
    e = {lv, 1'b1};
    if (sel) begin
      e[2] = smiN;
    end
    return e;
  endfunction
  // hang guard: a run past the limit counts as a failure
  initial begin
    repeat (100000) @(posedge refClk);
    num_errors++;
    final_report();
  end
  initial begin
    num_errors = 0;
    n_checks = 0;
    resetN = 1'b0;
    irqLevel = 15'h7fff;
    mgmtN = 1'b1;
    mgmtSel = 1'b1;
    startRequest = 1'b0;
    selectQuiet = 1'b0;
    extendClks = 3'h3;
    repeat (6) @(negedge refClk);
    resetN = 1'b1;
    check({13'h0, hostQuiet, devQuiet, cycleActive}, 16'h0);
    check(frameLevel, 16'hffff);
    // continuous back-to-back cycles over every extension and frame 3 use
    startRequest = 1'b1;
    for (i = 0; i < 6; i++) begin
      put(pat[i], i[0], i[1]);
      extendClks = 3'(i + 2);
      read_frames(seen);
      read_frames(seen);
      check(seen, expect_frames(pat[i], i[0], i[1]));
      check({14'h0, hostQuiet, devQuiet}, 16'h0);
    end
    // a two-clock stop switches both ends to quiet; the request drops only once
    // the next cycle runs, since a continuous link has no other starter
    selectQuiet = 1'b1;
    wait_active();
    startRequest = 1'b0;
    read_frames(seen);
    check({14'h0, hostQuiet, devQuiet}, 16'h3);
    wait_done(1500, got);
    check({15'h0, got}, 16'h0);
    put(15'h7fef, 1'b1, 1'b1);
    read_frames(seen);
    check(seen, expect_frames(15'h7fef, 1'b1, 1'b1));
    // a change after its frame has passed forces a further device start
    put(15'h3fef, 1'b1, 1'b1);
    wait_active();
    repeat (200) @(negedge refClk);
    irqLevel = 15'h3fee;
    read_frames(seen);
    check(seen, expect_frames(15'h3fef, 1'b1, 1'b1));
    read_frames(seen);
    check(seen, expect_frames(15'h3fee, 1'b1, 1'b1));
    // reset in mid-cycle; frame 3 now carries IRQ2, so its change starts that cycle
    put(15'h3fec, 1'b0, 1'b1);
    wait_active();
    resetN = 1'b0;
    repeat (6) @(negedge refClk);
    check({13'h0, hostQuiet, devQuiet, cycleActive}, 16'h0);
    check({15'h0, sia_link_if_inst.sirq}, 16'h1);
    resetN = 1'b1;
    // host-led cycle with a three-clock stop keeps the device passive
    selectQuiet = 1'b0;
    startRequest = 1'b1;
    wait_active();
    startRequest = 1'b0;
    read_frames(seen);
    check(seen, expect_frames(15'h3fec, 1'b0, 1'b1));
    check({14'h0, hostQuiet, devQuiet}, 16'h0);
    put(15'h7fff, 1'b0, 1'b0);
    wait_done(1500, got);
    check({15'h0, got}, 16'h0);
    final_report();
  end
endmodule
